// *** hw/mitb_regs.svh ***
`ifndef MITB_REGS_SVH
`define MITB_REGS_SVH

// Register byte offsets
`define MITB_OFF_CTRL 12'h000
`define MITB_OFF_FLAGS 12'h004
`define MITB_OFF_ENABLE 12'h008
`define MITB_OFF_PSC 12'h00c
`define MITB_OFF_TB0 12'h010
`define MITB_OFF_TB1 12'h014
`define MITB_OFF_STATUS 12'h018

// Field positions
`define MITB_CTRL_GIE_BIT 0
`define MITB_TB_RUN_BIT 7
`define MITB_TB_PER_MSB 2
`define MITB_PSC_MSB 1
`define MITB_STAT_REQ_BIT 0
`define MITB_STAT_IDX_LSB 4
`define MITB_STAT_IDX_MSB 7

// Reset values
`define MITB_RST_FLAGS 9'h000
`define MITB_RST_ENABLE 9'h000
`define MITB_RST_PSC 2'h0
`define MITB_RST_TB_PER 3'h0

// Source indices in priority order, 0 highest
`define MITB_SRC_LVD 0
`define MITB_SRC_ADC 1
`define MITB_SRC_NV 2
`define MITB_SRC_STMA 3
`define MITB_SRC_STMP 4
`define MITB_SRC_PTMA 5
`define MITB_SRC_PTMP 6
`define MITB_SRC_TB0 7
`define MITB_SRC_TB1 8
`define MITB_NSRC 9

// Vector addresses: base plus index times step
`define MITB_VEC_BASE 12'h004
`define MITB_VEC_SHIFT 2

// Prescaler source codes and divider
`define MITB_PSC_SYS 2'h0
`define MITB_PSC_SYS4 2'h1
`define MITB_SYS4_LAST 2'h3

// Time-base period exponent range
`define MITB_TB_MIN_EXP 8
`define MITB_TB_MAX_EXP 15

`endif

// *** hw/mitb_pkg.sv ***
package mitb_pkg;
    // Event strobes from the peripherals, same clock domain
    typedef struct packed {
        logic lvd_low;
        logic adc_done;
        logic nv_done;
        logic stm_a;
        logic stm_p;
        logic ptm_a;
        logic ptm_p;
    } mitb_evt_t;

    // Handshake from the core sequencer
    typedef struct packed {
        logic ack;
        logic ret;
        logic interrupt_return_instruction;
    } mitb_core_t;

    typedef logic [3:0] mitb_idx_t;
    typedef logic [11:0] mitb_vec_t;
endpackage : mitb_pkg

// *** hw/mitb_timebase.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "mitb_regs.svh"

module mitb_timebase
    import mitb_pkg::*;
#(
    parameter int CNT_W = `MITB_TB_MAX_EXP
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic run,
    input wire logic [2:0] period,
    output logic overflow
);
    initial begin
        if (CNT_W != `MITB_TB_MAX_EXP) begin
            $error("mitb_timebase: CNT_W must equal the largest period exponent");
        end
    end

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] mask;
    logic ovf_q;
    logic ovf_d;

    always_comb begin
        // Low 8+period bits all ones marks the last prescaler clock of a period
        mask = {CNT_W{1'b1}} >> (4'(`MITB_TB_MAX_EXP - `MITB_TB_MIN_EXP) - {1'b0, period});
        cnt_d = cnt_q;
        ovf_d = 1'b0;
        if (!run) begin
            cnt_d = '0;
        end else if (tick) begin
            cnt_d = cnt_q + CNT_W'(1);
            ovf_d = ((cnt_q & mask) == mask);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            ovf_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            ovf_q <= ovf_d;
        end
    end

    assign overflow = ovf_q;

    ovf_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
        overflow |-> $past(run) && $past(tick))
        else $error("time-base overflow without a running prescaler clock");
endmodule : mitb_timebase
`default_nettype wire

// *** hw/mitb_top.sv ***
// How it works
// - Low-voltage detector report sets the low-voltage flag.
// - Conversion completion sets the conversion-done flag.
// - End of each nonvolatile write cycle sets its flag.
// - Each timer module has comparator A and P flags, each with own enable.
// - Vector only when flag, global enable, source enable set and stack not full.
// - Servicing a request clears that source's flag.
// - Servicing any request clears the global enable.
// - Each time-base sets its flag on divider overflow.
// - Prescaler field: 00 system clock, 01 system clock/4, 1x sub clock.
// - Time-base zero: bit 7 runs it, bits 2-0 pick 2^(8+code) period.
// - Time-base one uses the same layout.
// - Unused bits of prescaler and time-base registers read zero.
// - In sleep or idle any flag rising wakes the device, enables ignored.
// - A set flag stays until serviced or cleared by software.
// - Vectoring pushes only the program counter; nothing else saved.
// - Interrupt return sets global enable; plain return leaves it low.
// - Global enable low blocks every interrupt.
// - Blocked requests still set and hold their flags.
`timescale 1ns/1ns
`default_nettype none
`include "mitb_regs.svh"

module mitb_top
    import mitb_pkg::*;
#(
    parameter int NSRC = `MITB_NSRC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire mitb_evt_t events,
    input wire logic sub_clock,
    input wire mitb_core_t core,
    input wire logic stack_full,
    input wire logic sleep_mode,
    output logic irq_req,
    output mitb_vec_t irq_vector,
    output logic wake
);
    initial begin
        if (NSRC != `MITB_NSRC) begin
            $error("mitb_top: NSRC must match the source map");
        end
    end

    // Control state
    logic gie_q, gie_d;
    logic [NSRC-1:0] flags_q, flags_d;
    logic [NSRC-1:0] en_q, en_d;
    logic [1:0] psc_q, psc_d;
    logic [1:0] tb_run_q, tb_run_d;
    logic [2:0] tb_per_q [2];
    logic [2:0] tb_per_d [2];
    logic req_q, req_d;
    mitb_idx_t idx_q, idx_d;
    logic wake_q, wake_d;
    logic [31:0] rdata_q, rdata_d;

    // Prescaler state
    logic [1:0] div4_q, div4_d;
    logic sub_s1_q, sub_s2_q, sub_s3_q;
    logic psc_tick;
    logic [1:0] tb_ovf;

    // Bus decode
    logic wr_en, setup;
    logic wr_ctrl, wr_flags, wr_en_reg, wr_psc, wr_tb0, wr_tb1;
    logic addr_ok;
    logic ack_take;
    logic [NSRC-1:0] set_vec;
    logic [NSRC-1:0] pend;

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite;
    assign pready = 1'b1;

    always_comb begin
        wr_ctrl = 1'b0;
        wr_flags = 1'b0;
        wr_en_reg = 1'b0;
        wr_psc = 1'b0;
        wr_tb0 = 1'b0;
        wr_tb1 = 1'b0;
        addr_ok = 1'b1;
        if (paddr == `MITB_OFF_CTRL) begin
            wr_ctrl = wr_en;
        end else if (paddr == `MITB_OFF_FLAGS) begin
            wr_flags = wr_en;
        end else if (paddr == `MITB_OFF_ENABLE) begin
            wr_en_reg = wr_en;
        end else if (paddr == `MITB_OFF_PSC) begin
            wr_psc = wr_en;
        end else if (paddr == `MITB_OFF_TB0) begin
            wr_tb0 = wr_en;
        end else if (paddr == `MITB_OFF_TB1) begin
            wr_tb1 = wr_en;
        end else if (paddr == `MITB_OFF_STATUS) begin
            addr_ok = 1'b1;
        end else begin
            addr_ok = 1'b0;
        end
    end

    assign pslverr = psel && penable && !addr_ok;

    // Read data is captured in the setup cycle and shown in the access cycle
    always_comb begin
        rdata_d = rdata_q;
        if (setup) begin
            if (paddr == `MITB_OFF_CTRL) begin
                rdata_d = 32'(gie_q);
            end else if (paddr == `MITB_OFF_FLAGS) begin
                rdata_d = 32'(flags_q);
            end else if (paddr == `MITB_OFF_ENABLE) begin
                rdata_d = 32'(en_q);
            end else if (paddr == `MITB_OFF_PSC) begin
                rdata_d = 32'(psc_q);
            end else if (paddr == `MITB_OFF_TB0) begin
                rdata_d = 32'({tb_run_q[0], 4'h0, tb_per_q[0]});
            end else if (paddr == `MITB_OFF_TB1) begin
                rdata_d = 32'({tb_run_q[1], 4'h0, tb_per_q[1]});
            end else if (paddr == `MITB_OFF_STATUS) begin
                rdata_d = 32'({idx_q, 3'h0, req_q});
            end else begin
                rdata_d = 32'h0000_0000;
            end
        end
    end

    assign prdata = rdata_q;

    // Prescaler clock enable; sub clock passes two flops before the edge detector
    always_comb begin
        div4_d = div4_q + 2'h1;
        if (psc_q == `MITB_PSC_SYS) begin
            psc_tick = 1'b1;
        end else if (psc_q == `MITB_PSC_SYS4) begin
            psc_tick = (div4_q == `MITB_SYS4_LAST);
        end else begin
            psc_tick = sub_s2_q && !sub_s3_q;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_tb
            mitb_timebase #(
                .CNT_W(`MITB_TB_MAX_EXP)
            ) u_tb (
                .pclk(pclk),
                .presetn(presetn),
                .tick(psc_tick),
                .run(tb_run_q[g]),
                .period(tb_per_q[g]),
                .overflow(tb_ovf[g])
            );
        end
    endgenerate

    // Hardware set strobes
    always_comb begin
        set_vec = '0;
        set_vec[`MITB_SRC_LVD] = events.lvd_low;
        set_vec[`MITB_SRC_ADC] = events.adc_done;
        set_vec[`MITB_SRC_NV] = events.nv_done;
        set_vec[`MITB_SRC_STMA] = events.stm_a;
        set_vec[`MITB_SRC_STMP] = events.stm_p;
        set_vec[`MITB_SRC_PTMA] = events.ptm_a;
        set_vec[`MITB_SRC_PTMP] = events.ptm_p;
        set_vec[`MITB_SRC_TB0] = tb_ovf[0];
        set_vec[`MITB_SRC_TB1] = tb_ovf[1];
    end

    // The core takes the vector and pushes only its program counter
    assign ack_take = core.ack && req_q;

    always_comb begin
        flags_d = flags_q;
        en_d = en_q;
        gie_d = gie_q;
        psc_d = psc_q;
        tb_run_d = tb_run_q;
        tb_per_d = tb_per_q;
        if (wr_flags) begin
            flags_d = pwdata[NSRC-1:0];
        end
        if (wr_en_reg) begin
            en_d = pwdata[NSRC-1:0];
        end
        if (wr_psc) begin
            psc_d = pwdata[`MITB_PSC_MSB:0];
        end
        if (wr_tb0) begin
            tb_run_d[0] = pwdata[`MITB_TB_RUN_BIT];
            tb_per_d[0] = pwdata[`MITB_TB_PER_MSB:0];
        end
        if (wr_tb1) begin
            tb_run_d[1] = pwdata[`MITB_TB_RUN_BIT];
            tb_per_d[1] = pwdata[`MITB_TB_PER_MSB:0];
        end
        if (wr_ctrl) begin
            gie_d = pwdata[`MITB_CTRL_GIE_BIT];
        end
        if (core.interrupt_return_instruction) begin
            gie_d = 1'b1;
        end
        if (ack_take) begin
            flags_d[idx_q] = 1'b0;
            gie_d = 1'b0;
        end
        // A new event beats any clear in the same cycle
        flags_d = flags_d | set_vec;
    end

    // Request and vector are computed from the next state so they never lag it
    always_comb begin
        pend = flags_d & en_d;
        req_d = gie_d && !stack_full && (pend != '0);
        idx_d = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (pend[i]) begin
                idx_d = mitb_idx_t'(i);
            end
        end
        wake_d = sleep_mode && ((flags_d & ~flags_q) != '0);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gie_q <= 1'b0;
            flags_q <= `MITB_RST_FLAGS;
            en_q <= `MITB_RST_ENABLE;
            psc_q <= `MITB_RST_PSC;
            tb_run_q <= 2'h0;
            tb_per_q[0] <= `MITB_RST_TB_PER;
            tb_per_q[1] <= `MITB_RST_TB_PER;
            req_q <= 1'b0;
            idx_q <= '0;
            wake_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            div4_q <= 2'h0;
            sub_s1_q <= 1'b0;
            sub_s2_q <= 1'b0;
            sub_s3_q <= 1'b0;
        end else begin
            gie_q <= gie_d;
            flags_q <= flags_d;
            en_q <= en_d;
            psc_q <= psc_d;
            tb_run_q <= tb_run_d;
            tb_per_q <= tb_per_d;
            req_q <= req_d;
            idx_q <= idx_d;
            wake_q <= wake_d;
            rdata_q <= rdata_d;
            div4_q <= div4_d;
            sub_s1_q <= sub_clock;
            sub_s2_q <= sub_s1_q;
            sub_s3_q <= sub_s2_q;
        end
    end

    assign irq_req = req_q;
    assign irq_vector = `MITB_VEC_BASE + (mitb_vec_t'(idx_q) << `MITB_VEC_SHIFT);
    assign wake = wake_q;

    lvd_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        events.lvd_low |=> flags_q[`MITB_SRC_LVD])
        else $error("low-voltage report did not set its flag");

    adc_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        events.adc_done |=> flags_q[`MITB_SRC_ADC])
        else $error("conversion done did not set its flag");

    nv_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        events.nv_done |=> flags_q[`MITB_SRC_NV])
        else $error("write done did not set its flag");

    tm_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> (flags_q[`MITB_SRC_PTMP:`MITB_SRC_STMA]
            | ~$past({events.ptm_p, events.ptm_a, events.stm_p, events.stm_a})) == 4'hf)
        else $error("timer match did not set its flag");

    req_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
        irq_req |-> gie_q && ((flags_q & en_q) != '0) && flags_q[idx_q] && en_q[idx_q])
        else $error("request raised without a cause");

    gie_block_a: assert property (@(posedge pclk) disable iff (!presetn)
        !gie_q |-> !irq_req)
        else $error("request raised with global enable low");

    ack_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        ack_take && !wr_flags && !set_vec[idx_q] |=> !flags_q[$past(idx_q)])
        else $error("serviced flag not cleared");

    ack_gie_a: assert property (@(posedge pclk) disable iff (!presetn)
        ack_take |=> !gie_q && !irq_req)
        else $error("global enable not cleared on service");

    interrupt_return_instruction_gie_a: assert property (@(posedge pclk) disable iff (!presetn)
        core.interrupt_return_instruction && !ack_take |=> gie_q)
        else $error("interrupt return did not set global enable");

    ret_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        core.ret && !core.interrupt_return_instruction && !gie_q && !wr_ctrl |=> !gie_q)
        else $error("plain return changed global enable");

    flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !ack_take && !wr_flags |=> (flags_q & $past(flags_q)) == $past(flags_q))
        else $error("flag dropped without service or software clear");

    wake_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
        sleep_mode && events.adc_done && !flags_q[`MITB_SRC_ADC] |=> wake)
        else $error("rising flag in sleep did not wake");

    prio_pick_a: assert property (@(posedge pclk) disable iff (!presetn)
        irq_req && idx_q != '0 |-> !(flags_q[`MITB_SRC_LVD] && en_q[`MITB_SRC_LVD]))
        else $error("lower priority source chosen over low-voltage");
endmodule : mitb_top
`default_nettype wire

// *** dv/mitb_core_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module mitb_core_model
    import mitb_pkg::*;
#(
    parameter int DEPTH = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic irq_req,
    input wire mitb_vec_t irq_vector,
    input wire logic ack_en,
    input wire logic hold_full,
    input wire logic ret_go,
    input wire logic ret_int,
    output mitb_core_t core,
    output logic stack_full,
    output mitb_vec_t taken_vec,
    output logic [7:0] taken_cnt
);
    logic [3:0] depth_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core <= '0;
            depth_q <= 4'h0;
            taken_vec <= '0;
            taken_cnt <= 8'h00;
        end else begin
            core.ack <= ack_en && irq_req && !core.ack && !stack_full;
            core.ret <= ret_go;
            core.interrupt_return_instruction <= ret_go && ret_int;
            if (core.ack && irq_req) begin
                // Only the return address is pushed
                depth_q <= depth_q + 4'h1;
                taken_vec <= irq_vector;
                taken_cnt <= taken_cnt + 8'h01;
            end else if (core.ret && depth_q != 4'h0) begin
                depth_q <= depth_q - 4'h1;
            end
        end
    end

    // Service code makes no nested calls, so each interrupt takes one slot
    assign stack_full = hold_full || (depth_q >= 4'(DEPTH));
endmodule : mitb_core_model

`default_nettype wire

// *** dv/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "mitb_regs.svh"

module testbench
    import mitb_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    mitb_evt_t events;
    mitb_core_t core;
    logic sub_clock, stack_full, sleep_mode, irq_req, wake;
    logic ack_en, hold_full, ret_go, ret_int;
    mitb_vec_t irq_vector, taken_vec;
    logic [7:0] taken_cnt;
    int n_fail, comparisons, cyc, nwake, last_wake;

    mitb_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .events(events), .sub_clock(sub_clock), .core(core),
        .stack_full(stack_full), .sleep_mode(sleep_mode), .irq_req(irq_req),
        .irq_vector(irq_vector), .wake(wake));

    mitb_core_model core_model (.pclk(pclk), .presetn(presetn), .irq_req(irq_req),
        .irq_vector(irq_vector), .ack_en(ack_en), .hold_full(hold_full), .ret_go(ret_go),
        .ret_int(ret_int), .core(core), .stack_full(stack_full), .taken_vec(taken_vec),
        .taken_cnt(taken_cnt));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Slow sub clock: one prescaler tick every 6 pclk cycles
    initial begin
        sub_clock = 1'b0;
        forever #30 sub_clock = ~sub_clock;
    end

    // Sampled away from the launching edge so the registered wake pulse is settled
    always @(negedge pclk) begin
        cyc++;
        if (wake === 1'b1) begin
            nwake++;
            last_wake = cyc;
        end
        if (cyc == 40000) begin
            n_fail++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask : wr

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask : rdchk

    task automatic pulse(input logic [6:0] v);
        @(posedge pclk);
        events <= mitb_evt_t'(v);
        @(posedge pclk);
        events <= '0;
    endtask : pulse

    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : settle

    task automatic t_regs();
        for (int a = 0; a <= 24; a += 4) rdchk(12'(a), 32'h0);
        rdchk(12'h01c, 32'h0);
        chk(last_err, 1'b1);
        wr(`MITB_OFF_PSC, 32'hff);
        rdchk(`MITB_OFF_PSC, 32'h03);
        wr(`MITB_OFF_TB0, 32'hff);
        rdchk(`MITB_OFF_TB0, 32'h87);
        wr(`MITB_OFF_TB1, 32'hff);
        rdchk(`MITB_OFF_TB1, 32'h87);
        wr(`MITB_OFF_TB0, 32'h0);
        wr(`MITB_OFF_TB1, 32'h0);
        wr(`MITB_OFF_PSC, 32'h0);
    endtask : t_regs

    // Strobes while disabled and blocked must still be recorded and held
    task automatic t_events();
        for (int k = 0; k < 7; k++) begin
            pulse(7'h40 >> k);
            rdchk(`MITB_OFF_FLAGS, (32'h2 << k) - 32'h1);
        end
        wr(`MITB_OFF_ENABLE, 32'h1ff);
        settle(6);
        chk(irq_req, 1'b0);
        rdchk(`MITB_OFF_FLAGS, 32'h7f);
        wr(`MITB_OFF_ENABLE, 32'h0);
        wr(`MITB_OFF_FLAGS, 32'h0);
    endtask : t_events

    task automatic t_vectors();
        int n;
        wr(`MITB_OFF_FLAGS, 32'h1ff);
        wr(`MITB_OFF_CTRL, 32'h1);
        settle(8);
        chk(irq_req, 1'b0);
        rdchk(`MITB_OFF_FLAGS, 32'h1ff);
        hold_full <= 1'b1;
        ack_en <= 1'b1;
        wr(`MITB_OFF_ENABLE, 32'h1ff);
        settle(8);
        chk(taken_cnt, 8'h0);
        hold_full <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            n = 0;
            while (taken_cnt !== 8'(i + 1) && n < 100) begin
                settle(1);
                n++;
            end
            chk(taken_vec, 12'h004 + 12'(4 * i));
            rdchk(`MITB_OFF_CTRL, 32'h0);
            rdchk(`MITB_OFF_FLAGS, (32'h1ff << (i + 1)) & 32'h1ff);
            @(posedge pclk);
            ret_go <= 1'b1;
            ret_int <= (i < 8);
            @(posedge pclk);
            ret_go <= 1'b0;
        end
        settle(4);
        rdchk(`MITB_OFF_CTRL, 32'h0);
        ack_en <= 1'b0;
        wr(`MITB_OFF_ENABLE, 32'h0);
    endtask : t_vectors

    task automatic t_wake();
        int m;
        wr(`MITB_OFF_FLAGS, 32'h2);
        @(posedge pclk);
        sleep_mode <= 1'b1;
        m = nwake;
        pulse(7'h20);
        settle(4);
        chk(nwake - m, 32'h0);
        pulse(7'h40);
        settle(4);
        chk(nwake - m, 32'h1);
        wr(`MITB_OFF_FLAGS, 32'h0);
    endtask : t_wake

    task automatic wait_wake(input int target);
        int n;
        n = 0;
        while (nwake < target && n < 5000) begin
            settle(1);
            n++;
        end
        if (nwake < target) n_fail++;
    endtask : wait_wake

    // Interval between two overflows, seen as wake pulses with the flag cleared between
    task automatic t_tb(input logic [1:0] psc, input logic [11:0] off, input logic [2:0] code,
                        input int exp);
        int m, t1;
        wr(`MITB_OFF_PSC, {30'h0, psc});
        wr(off, {24'h0, 5'h10, code});
        m = nwake;
        wait_wake(m + 1);
        t1 = last_wake;
        wr(`MITB_OFF_FLAGS, 32'h0);
        wait_wake(m + 2);
        chk(last_wake - t1, exp);
        wr(off, 32'h0);
        wr(`MITB_OFF_FLAGS, 32'h0);
    endtask : t_tb

    initial begin
        n_fail = 0;
        comparisons = 0;
        cyc = 0;
        nwake = 0;
        last_wake = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        events = '0;
        sleep_mode = 1'b0;
        ack_en = 1'b0;
        hold_full = 1'b0;
        ret_go = 1'b0;
        ret_int = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_events();
        t_vectors();
        t_wake();
        t_tb(2'h0, `MITB_OFF_TB0, 3'h0, 256);
        t_tb(2'h1, `MITB_OFF_TB0, 3'h0, 1024);
        t_tb(2'h0, `MITB_OFF_TB1, 3'h1, 512);
        t_tb(2'h2, `MITB_OFF_TB1, 3'h0, 1536);
        stop_test();
    end
endmodule : testbench

`default_nettype wire
